// ---- hdl/ccdi_params.svh ----
/*
 * constants of the caption decoder two-wire slave port: addresses,
 * status byte fields, reset values of the pin samplers.
 * assumes inclusion by the pin sampler and the port modules only.
 */
`ifndef CCDI_PARAMS_SVH
`define CCDI_PARAMS_SVH

// write address bytes, read address is the same with bit 0 set
`define CCDI_ADDR_WR_LOW 8'h28
`define CCDI_ADDR_WR_HIGH 8'h2A

// bits in one word on the wire
`define CCDI_BITS_PER_WORD 4'h8

// status byte field positions
`define CCDI_STAT_READY_BIT 3'h0
`define CCDI_STAT_DAV_BIT 3'h1
`define CCDI_STAT_TWO_BIT 3'h2

// byte shifted out when nothing is waiting (line stays released)
`define CCDI_IDLE_BYTE 8'hFF

// read byte index: status, first data, second data
`define CCDI_RD_STATUS 2'h0
`define CCDI_RD_DATA0 2'h1
`define CCDI_RD_DATA1 2'h2
`define CCDI_RD_LAST 2'h3

// write byte index: address, command, data
`define CCDI_WR_ADDR 2'h0
`define CCDI_WR_CMD 2'h1
`define CCDI_WR_DATA 2'h2

// pin samplers reset to the idle bus with every pin high; the mode pin high holds the port cleared
`define CCDI_PINS_IDLE 5'h1F

`endif

// ---- hdl/ccdi_pkg.sv ----
/*
 * types of the caption decoder two-wire slave port.
 * assumes ccdi_params.svh is on the include path.
 */
package ccdi_pkg;

    typedef logic [7:0] ccdi_byte_t;

    // port states, gray steps along idle-addr-ack-write / read-mack
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_addr = 3'h1,
        st_ack = 3'h3,
        st_write = 3'h2,
        st_read = 3'h6,
        st_mack = 3'h7,
        st_ignore = 3'h5
    } ccdi_state_e;

    // raw or sampled pins
    typedef struct packed {
        logic scl;
        logic sda;
        logic mode;
        logic enable;
        logic asel;
    } ccdi_pins_s;

    // bytes staged for the master to read
    typedef struct packed {
        logic two;
        ccdi_byte_t byte0;
        ccdi_byte_t byte1;
    } ccdi_stage_s;

    // command handed to the decoder core
    typedef struct packed {
        ccdi_byte_t first;
        ccdi_byte_t data;
    } ccdi_cmd_s;

endpackage

// ---- hdl/ccdi_sync.sv ----
/*
 * two flip-flop sampler for the port pins.
 * assumes pins are asynchronous to sys_clk; reset is synchronous.
 */
`timescale 1ns/1ns
`include "ccdi_params.svh"

module ccdi_sync import ccdi_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset,
    input wire ccdi_pins_s pins_raw,
    output ccdi_pins_s pins_sync
);

    ccdi_pins_s meta;

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta <= `CCDI_PINS_IDLE;
            pins_sync <= `CCDI_PINS_IDLE;
        end else begin
            meta <= pins_raw;
            pins_sync <= meta;
        end
    end

endmodule // ccdi_sync

// ---- hdl/ccdi_slave.sv ----
/*
 * two-wire slave port of the caption decoder: start/stop detection,
 * address match, command receive, status and data transmit.
 * assumes sda is open drain with a pull-up and link_scl is the serial
 * clock pin itself, also fed to scl_in; decoder core gives cmd_two_bytes
 * combinationally from cmd.first.
 */
`timescale 1ns/1ns
`include "ccdi_params.svh"

module ccdi_slave import ccdi_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic link_scl,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic serial_mode_select,
    input wire logic port_enable_pin,
    input wire logic address_select,
    input wire logic device_ready,
    input wire logic stage_valid,
    input wire ccdi_stage_s stage,
    input wire logic cmd_two_bytes,
    output ccdi_cmd_s cmd,
    output logic cmd_strobe,
    output logic data_available_flag,
    output logic two_bytes_pending_flag,
    output logic spare_serial_output,
    output logic spare_serial_output_oe,
    output logic port_reset
);

    ccdi_pins_s pins_raw;
    ccdi_pins_s pins_s;
    ccdi_state_e state;
    ccdi_byte_t link_word;
    ccdi_byte_t tx_shift;
    ccdi_byte_t out0;
    ccdi_byte_t out1;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [1:0] rd_idx;
    logic scl_d;
    logic sda_d;
    logic ack_seen;
    logic rw;

    // link domain: shift in sda on each scl rise, msb first
    // sample on rise
    always_ff @(posedge link_scl) begin
        link_word <= {link_word[6:0], sda_in};
    end

    assign pins_raw = '{scl: scl_in, sda: sda_in, mode: serial_mode_select,
                        enable: port_enable_pin, asel: address_select};

    ccdi_sync u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pins_raw(pins_raw),
        .pins_sync(pins_s)
    );

    // previous sampled levels for edge detection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= pins_s.scl;
            sda_d <= pins_s.sda;
        end
    end

    // bus events and port gating
    wire hold_rst = ~pins_s.mode & ~pins_s.enable;
    wire clr = reset | hold_rst | pins_s.mode;
    wire steady_high = scl_d & pins_s.scl;
    wire start_ev = steady_high & sda_d & ~pins_s.sda;
    wire stop_ev = steady_high & ~sda_d & pins_s.sda;
    wire rise = pins_s.scl & ~scl_d;
    wire fall = ~pins_s.scl & scl_d;
    wire word_done = fall & (bit_cnt == `CCDI_BITS_PER_WORD);

    // address match; the word is stable while scl is low
    // address select
    wire [7:0] my_addr = pins_s.asel ? `CCDI_ADDR_WR_HIGH
                                     : `CCDI_ADDR_WR_LOW;
    wire addr_hit = link_word[7:1] == my_addr[7:1];
    wire master_ack = ~link_word[0];

    // status byte and the next byte to send
    // count flag
    wire [7:0] status_byte =
        (ccdi_byte_t'(device_ready) << `CCDI_STAT_READY_BIT) |
        (ccdi_byte_t'(data_available_flag) << `CCDI_STAT_DAV_BIT) |
        (ccdi_byte_t'(two_bytes_pending_flag) << `CCDI_STAT_TWO_BIT);
    wire [1:0] rd_next = (rd_idx == `CCDI_RD_LAST) ? rd_idx
                                                   : rd_idx + 2'h1;
    wire sel0 = data_available_flag & (rd_next == `CCDI_RD_DATA0);
    wire sel1 = data_available_flag & two_bytes_pending_flag &
                (rd_next == `CCDI_RD_DATA1);
    wire [7:0] next_tx = sel0 ? out0 : (sel1 ? out1 : `CCDI_IDLE_BYTE);
    wire last_data = data_available_flag &
        ((rd_idx == `CCDI_RD_DATA0 & ~two_bytes_pending_flag) |
         (rd_idx == `CCDI_RD_DATA1 & two_bytes_pending_flag));
    // clear after the eighth bit of the final byte
    wire clr_dav = (state == st_read) & word_done & last_data;
    wire ack_end = fall & ack_seen;
    wire wr_complete = (byte_idx == `CCDI_WR_DATA) |
                       ((byte_idx == `CCDI_WR_CMD) & ~cmd_two_bytes);

    // staged output bytes and flags; a new staging beats the clear
    always_ff @(posedge sys_clk) begin
        if (reset | hold_rst) begin
            data_available_flag <= 1'b0;
            two_bytes_pending_flag <= 1'b0;
            out0 <= 8'h00;
            out1 <= 8'h00;
        end else if (stage_valid) begin
            data_available_flag <= 1'b1;
            two_bytes_pending_flag <= stage.two;
            out0 <= stage.byte0;
            out1 <= stage.byte1;
        end else if (clr_dav) begin
            data_available_flag <= 1'b0;
        end
    end

    // port state machine
    always_ff @(posedge sys_clk) begin
        cmd_strobe <= 1'b0;
        if (clr) begin
            state <= st_idle;
            bit_cnt <= 4'h0;
            ack_seen <= 1'b0;
            rw <= 1'b0;
            byte_idx <= `CCDI_WR_ADDR;
            rd_idx <= `CCDI_RD_STATUS;
            tx_shift <= `CCDI_IDLE_BYTE;
            sda_oe <= 1'b0;
            cmd <= '0;
        end else if (start_ev) begin
            state <= st_addr;
            bit_cnt <= 4'h0;
            ack_seen <= 1'b0;
            byte_idx <= `CCDI_WR_ADDR;
            rd_idx <= `CCDI_RD_STATUS;
            sda_oe <= 1'b0;
        end else if (stop_ev) begin
            state <= st_idle;
            sda_oe <= 1'b0;
        end else begin
            if (rise) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            unique case (state)
                st_addr: begin
                    if (word_done) begin
                        ack_seen <= 1'b0;
                        if (addr_hit) begin
                            rw <= link_word[0];
                            sda_oe <= 1'b1;
                            state <= st_ack;
                        end else begin
                            state <= st_ignore;
                        end
                    end
                end
                st_ack: begin
                    if (rise) begin
                        ack_seen <= 1'b1;
                    end else if (ack_end) begin
                        bit_cnt <= 4'h0;
                        ack_seen <= 1'b0;
                        if (rw) begin
                            tx_shift <= status_byte;
                            sda_oe <= ~status_byte[7];
                            state <= st_read;
                        end else if (wr_complete) begin
                            sda_oe <= 1'b0;
                            cmd_strobe <= 1'b1;
                            state <= st_ignore;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= st_write;
                        end
                    end
                end
                st_write: begin
                    if (word_done) begin
                        sda_oe <= 1'b1;
                        ack_seen <= 1'b0;
                        byte_idx <= byte_idx + 2'h1;
                        state <= st_ack;
                        if (byte_idx == `CCDI_WR_ADDR) begin
                            cmd.first <= link_word;
                        end else begin
                            cmd.data <= link_word;
                        end
                    end
                end
                st_read: begin
                    if (word_done) begin
                        sda_oe <= 1'b0;
                        ack_seen <= 1'b0;
                        state <= st_mack;
                    end else if (fall) begin
                        tx_shift <= {tx_shift[6:0], 1'b1};
                        sda_oe <= ~tx_shift[6];
                    end
                end
                st_mack: begin
                    if (rise) begin
                        ack_seen <= 1'b1;
                    end else if (ack_end) begin
                        bit_cnt <= 4'h0;
                        ack_seen <= 1'b0;
                        if (master_ack) begin
                            rd_idx <= rd_next;
                            tx_shift <= next_tx;
                            sda_oe <= ~next_tx[7];
                            state <= st_read;
                        end else begin
                            state <= st_ignore;
                        end
                    end
                end
                st_idle, st_ignore: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    state <= st_idle;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // pin drivers held quiet; spare output unused in this mode
    // spare pin released
    always_ff @(posedge sys_clk) begin
        sda_out <= 1'b0;
        spare_serial_output <= 1'b0;
        spare_serial_output_oe <= 1'b0;
        port_reset <= reset | hold_rst;
    end

    property p_start;
        @(posedge sys_clk) disable iff (clr)
        start_ev |=> state == st_addr && !sda_oe;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");

    property p_stop;
        @(posedge sys_clk) disable iff (clr)
        stop_ev && !start_ev |=> state == st_idle && !sda_oe;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not end traffic");

    property p_drive_low;
        @(posedge sys_clk) disable iff (clr)
        $rose(sda_oe) |-> !pins_s.scl && $past(fall);
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("sda driven outside scl low");

    property p_addr_ack;
        @(posedge sys_clk) disable iff (clr)
        state == st_addr && word_done && addr_hit && !start_ev
        |=> sda_oe && state == st_ack;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acked");

    property p_foreign;
        @(posedge sys_clk) disable iff (clr)
        state == st_addr && word_done && !addr_hit
        |=> state == st_ignore ##1 !sda_oe;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign address answered");

    property p_quiet;
        @(posedge sys_clk) disable iff (clr)
        state == st_ignore |-> !sda_oe;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("surplus byte acked");

    property p_status;
        @(posedge sys_clk) disable iff (clr)
        state == st_ack && ack_end && rw && !start_ev && !stop_ev
        |=> state == st_read && tx_shift == $past(status_byte);
    endproperty
    a_status: assert property (p_status)
        else $error("status byte not sent first");

    property p_dav_clear;
        @(posedge sys_clk) disable iff (clr)
        clr_dav && !stage_valid |=> !data_available_flag;
    endproperty
    a_dav_clear: assert property (p_dav_clear)
        else $error("data available not cleared");

    property p_stage;
        @(posedge sys_clk) disable iff (reset || hold_rst)
        stage_valid |=> data_available_flag &&
            two_bytes_pending_flag == $past(stage.two) &&
            out0 == $past(stage.byte0);
    endproperty
    a_stage: assert property (p_stage)
        else $error("staged bytes not loaded");

    property p_hold;
        @(posedge sys_clk) disable iff (reset)
        hold_rst |=> state == st_idle && !sda_oe && port_reset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("port not held in reset");

    c_two_byte: cover property (@(posedge sys_clk)
        cmd_strobe && byte_idx == `CCDI_WR_DATA);
    c_three_read: cover property (@(posedge sys_clk)
        state == st_mack && rd_idx == `CCDI_RD_DATA1);
    c_foreign: cover property (@(posedge sys_clk)
        state == st_addr && word_done && !addr_hit);

endmodule // ccdi_slave

// ---- verif/ccdi_master_model.sv ----
/*
 * two-wire bus master model: start, stop, byte send and byte receive.
 * assumes the bench resolves sda from both open-drain pulls and a pull-up.
 */
`timescale 1ns/1ns

module ccdi_master_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // one clock: data set mid-low, sampled at the rise
    // low-phase change only
    task automatic bit_io(input logic v, output logic s);
        #31 sda_pull = ~v;
        #31 scl = 1'b1;
        s = sda;
        #63 scl = 1'b0;
    endtask

    // start or repeated start; steps kept off the system clock edges
    // start from high
    task automatic start();
        #1;
        while ($time % 5 != 2) #1;
        #31 sda_pull = 1'b0;
        #31 scl = 1'b1;
        #63 sda_pull = 1'b1;
        #60 scl = 1'b0;
    endtask

    // stop, then bus free time; clock stands high afterwards
    // stop condition
    task automatic stop();
        #31 sda_pull = 1'b1;
        #31 scl = 1'b1;
        #63 sda_pull = 1'b0;
        #60;
    endtask

    task automatic send(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, nack);
    endtask

    // receive a byte, ack it unless it is the last one
    // nack on last
    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask
endmodule // ccdi_master_model

// ---- verif/ccdi_slave_tb.sv ----
/*
 * self-checking bench of the two-wire slave port: reads, writes,
 * chaining, refusals, staging and pin reset.
 * assumes the package, the design files and the master model compile first.
 */
`timescale 1ns/1ns

module ccdi_slave_tb import ccdi_pkg::*;;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic serial_mode_select = 1'b0;
    logic port_enable_pin = 1'b1;
    logic address_select = 1'b0;
    logic device_ready = 1'b1;
    logic stage_valid = 1'b0;
    ccdi_stage_s stage = '0;
    logic scl, m_pull, sda_oe, sda_out, cmd_two_bytes, cmd_strobe;
    logic data_available_flag, two_bytes_pending_flag, port_reset;
    logic spare_serial_output, spare_serial_output_oe;
    wire sda;
    ccdi_cmd_s cmd;
    int fails = 0;
    int comparisons = 0;
    int strobes = 0;
    int cycles = 0;

    // open-drain wire with pull-up
    assign sda = ~(m_pull | (sda_oe & ~sda_out));
    // decoder stand-in: commands with the top bit set carry a data byte
    assign cmd_two_bytes = cmd.first[7];

    // system clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ccdi_slave i_ccdi_slave (
        .sys_clk(sys_clk), .reset(reset), .link_scl(scl), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .serial_mode_select(serial_mode_select),
        .port_enable_pin(port_enable_pin), .address_select(address_select),
        .device_ready(device_ready), .stage_valid(stage_valid),
        .stage(stage), .cmd_two_bytes(cmd_two_bytes), .cmd(cmd),
        .cmd_strobe(cmd_strobe), .data_available_flag(data_available_flag),
        .two_bytes_pending_flag(two_bytes_pending_flag),
        .spare_serial_output(spare_serial_output),
        .spare_serial_output_oe(spare_serial_output_oe),
        .port_reset(port_reset)
    );

    ccdi_master_model i_ccdi_master_model (
        .scl(scl),
        .sda_pull(m_pull),
        .sda(sda)
    );

    // command strobe count and hang limit
    always @(posedge sys_clk) begin
        cycles++;
        if (cmd_strobe === 1'b1) strobes++;
        if (cycles == 20000) begin
            fails++;
            $display("[ERR] %0t run took too long", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %0s finished", s);
    endtask

    // start plus address byte, answer compared
    task automatic addr(input logic [7:0] a, input logic want_nack);
        logic nk;
        i_ccdi_master_model.start();
        i_ccdi_master_model.send(a, nk);
        chk({7'h0, nk}, {7'h0, want_nack});
    endtask

    // read n bytes msb first, last one nacked, then stop
    task automatic rd(input logic [7:0] a, input int n, input logic [23:0] w);
        logic [7:0] b;
        addr(a, 1'b0);
        for (int i = 0; i < n; i++) begin
            i_ccdi_master_model.recv(i == n - 1, b);
            chk(b, w[23 - 8 * i -: 8]);
        end
        i_ccdi_master_model.stop();
    endtask

    // write n bytes; nk holds address then per-byte expected answers
    task automatic wr(input logic [7:0] a, input int n, input logic [23:0] d,
            input logic [3:0] nk);
        logic s;
        addr(a, nk[3]);
        for (int i = 0; i < n; i++) begin
            i_ccdi_master_model.send(d[23 - 8 * i -: 8], s);
            chk({7'h0, s}, {7'h0, nk[2 - i]});
        end
    endtask

    task automatic stage_load(input logic two, input logic [7:0] b0,
            input logic [7:0] b1);
        @(posedge sys_clk);
        stage_valid <= 1'b1;
        stage <= '{two: two, byte0: b0, byte1: b1};
        @(posedge sys_clk);
        stage_valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        // status read alone shows the ready bit and no data available
        rd(8'h29, 1, 24'h010000);
        chk({7'h0, data_available_flag}, 8'h00);
        done("status");
        wr(8'h28, 3, 24'h853C11, 4'b0001);
        i_ccdi_master_model.stop();
        repeat (4) @(posedge sys_clk);
        chk(8'(strobes), 8'h01);
        chk(cmd.first, 8'h85);
        chk(cmd.data, 8'h3C);
        done("write two");
        wr(8'h28, 2, 24'h050600, 4'b0010);
        wr(8'h28, 1, 24'h070000, 4'b0000);
        i_ccdi_master_model.stop();
        repeat (4) @(posedge sys_clk);
        chk(8'(strobes), 8'h03);
        chk(cmd.first, 8'h07);
        done("chain");
        wr(8'h28, 1, 24'h850000, 4'b0000);
        i_ccdi_master_model.stop();
        wr(8'h28, 1, 24'h090000, 4'b0000);
        i_ccdi_master_model.stop();
        repeat (4) @(posedge sys_clk);
        chk(8'(strobes), 8'h04);
        chk(cmd.first, 8'h09);
        done("stop abort");
        stage_load(1'b1, 8'hA5, 8'h5A);
        chk({6'h0, two_bytes_pending_flag, data_available_flag}, 8'h03);
        rd(8'h29, 1, 24'h070000);
        chk({7'h0, data_available_flag}, 8'h01);
        rd(8'h29, 3, 24'h07A55A);
        chk({7'h0, data_available_flag}, 8'h00);
        done("read three");
        @(posedge sys_clk);
        device_ready <= 1'b0;
        stage_load(1'b0, 8'hC3, 8'h00);
        rd(8'h29, 2, 24'h02C300);
        chk({7'h0, data_available_flag}, 8'h00);
        @(posedge sys_clk);
        device_ready <= 1'b1;
        done("read two");
        wr(8'h2A, 1, 24'h050000, 4'b1100);
        i_ccdi_master_model.stop();
        @(posedge sys_clk);
        address_select <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(8'h28, 0, 24'h000000, 4'b1000);
        rd(8'h2B, 1, 24'h010000);
        wr(8'h2A, 1, 24'h050000, 4'b0000);
        i_ccdi_master_model.stop();
        repeat (4) @(posedge sys_clk);
        chk(8'(strobes), 8'h05);
        done("address");
        stage_load(1'b1, 8'h11, 8'h22);
        port_enable_pin <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk({6'h0, port_reset, data_available_flag}, 8'h02);
        port_enable_pin <= 1'b1;
        serial_mode_select <= 1'b1;
        repeat (5) @(posedge sys_clk);
        wr(8'h2A, 0, 24'h000000, 4'b1000);
        i_ccdi_master_model.stop();
        chk({5'h0, sda_out, spare_serial_output, spare_serial_output_oe}, 8'h00);
        @(posedge sys_clk);
        serial_mode_select <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rd(8'h2B, 1, 24'h010000);
        done("pin reset");
        wrap_up();
    end
endmodule // ccdi_slave_tb
